/* File: bls_top.v */
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "bls_regs.vh"

module bls_top #(
	parameter [39:0] STARTUP_CYC = `BLS_STARTUP_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] TEST_TO_CYC = `BLS_TEST_TIMEOUT_S * `BLS_CLK_HZ,
	parameter [39:0] SETUP_TO_CYC = `BLS_SETUP_TIMEOUT_S * `BLS_CLK_HZ,
	parameter [39:0] LEARN_TO_CYC = `BLS_LEARN_TIMEOUT_S * `BLS_CLK_HZ,
	parameter [39:0] STEP_CYC = `BLS_STEP_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] CANCEL_CYC = `BLS_CANCEL_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] BLINK_CYC = `BLS_BLINK_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] AIM_DLY_CYC = `BLS_AIM_DELAY_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] BEEP_SHORT_CYC = `BLS_BEEP_SHORT_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] BEEP_GAP_CYC = `BLS_BEEP_GAP_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] BEEP_LONG_CYC = `BLS_BEEP_LONG_MS * `BLS_CLK_HZ / 40'd1000,
	parameter [39:0] DEB_CYC = `BLS_DEBOUNCE_MS * `BLS_CLK_HZ / 40'd1000
) (
	input wire sys_clk,
	input wire rst,
	input wire button_in,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg led_status,
	output reg serial_activity_indicator,
	output reg led_trigger,
	output reg led_good,
	output reg led_ready,
	output reg laser_on,
	output reg autofocus_run,
	output reg setup_run,
	output reg setup_store,
	output reg learn_run,
	output reg learn_store,
	output reg good_spot,
	output reg beep_high,
	output reg beep_low,
	output reg diag_msg_req
);
	localparam [9:0] S_STARTUP = 10'h001;
	localparam [9:0] S_IDLE = 10'h002;
	localparam [9:0] S_HOLD = 10'h004;
	localparam [9:0] S_TEST = 10'h008;
	localparam [9:0] S_AIM = 10'h010;
	localparam [9:0] S_AIM_CANCEL = 10'h020;
	localparam [9:0] S_SETUP = 10'h040;
	localparam [9:0] S_LEARN = 10'h080;
	localparam [9:0] S_LEARN_CANCEL = 10'h100;
	localparam [9:0] S_BEEP = 10'h200;

	// Function indicator for a selection: 1 test, 2 aim, 3 setup, 4 learn
	function [4:0] sel_led;
		input [2:0] sel;
		begin
			case (sel)
				3'd1: sel_led = 5'h08;
				3'd2: sel_led = 5'h04;
				3'd3: sel_led = 5'h02;
				3'd4: sel_led = 5'h01;
				default: sel_led = 5'h10;
			endcase
		end
	endfunction

	wire pressed;
	wire press_evt;
	wire release_evt;
	reg [2:0] ctrl;
	reg [6:0] rate;
	reg [3:0] evt;
	reg [9:0] state;
	reg [2:0] sel;
	reg [39:0] tmr;
	reg [39:0] blink_cnt;
	reg blink;
	reg test_fail;
	reg aim_af;
	reg beep_phase;
	reg beep_hi;
	reg [1:0] beeps_left;
	reg err_seen;
	reg [31:0] rd_data;
	reg rd_bad;
	reg [4:0] next_led;
	wire apb_wr;

	bls_debounce #(
		.DEB_CYC(DEB_CYC)
	) u_deb (
		.sys_clk(sys_clk),
		.rst(rst),
		.button_in(button_in),
		.pressed(pressed),
		.press_evt(press_evt),
		.release_evt(release_evt)
	);

	assign apb_wr = psel & penable & pwrite & pready;

	always @* begin
		rd_bad = 1'b0;
		case (paddr)
			`BLS_REG_CTRL: rd_data = {29'h0, ctrl};
			`BLS_REG_EVT: rd_data = 32'h0;
			`BLS_REG_RATE: rd_data = {25'h0, rate};
			`BLS_REG_STAT: rd_data = {11'h0, pressed, good_spot, test_fail, state, sel, led_status,
				serial_activity_indicator, led_trigger, led_good, led_ready};
			default: begin
				rd_data = 32'h0;
				rd_bad = 1'b1;
			end
		endcase
	end

	// APB slave, answers in the first access cycle
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			ctrl <= `BLS_CTRL_RESET;
			rate <= `BLS_RATE_RESET;
			evt <= 4'h0;
		end else begin
			pready <= psel & ~penable & ~pready;
			evt <= 4'h0;
			if (psel & ~penable) begin
				pslverr <= rd_bad;
				prdata <= pwrite ? 32'h0 : rd_data;
			end else if (~psel) begin
				pslverr <= 1'b0;
			end
			if (apb_wr & ~pslverr) begin
				case (paddr)
					`BLS_REG_CTRL: ctrl <= pwdata[2:0];
					`BLS_REG_EVT: evt <= pwdata[3:0];
					`BLS_REG_RATE: rate <= pwdata[6:0];
					default: ;
				endcase
			end
		end
	end

	// Free-running blink phase
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blink_cnt <= 40'h0;
			blink <= 1'b1;
		end else if (blink_cnt >= BLINK_CYC - 40'h1) begin
			blink_cnt <= 40'h0;
			blink <= ~blink;
		end else begin
			blink_cnt <= blink_cnt + 40'h1;
		end
	end

	// Sequencer
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= S_STARTUP;
			sel <= 3'd0;
			tmr <= 40'h0;
			test_fail <= 1'b0;
			aim_af <= 1'b0;
			beep_phase <= 1'b0;
			beep_hi <= 1'b0;
			beeps_left <= 2'd0;
			good_spot <= 1'b0;
			setup_store <= 1'b0;
			learn_store <= 1'b0;
		end else begin
			tmr <= tmr + 40'h1;
			setup_store <= 1'b0;
			learn_store <= 1'b0;
			case (state)
				S_STARTUP: begin
					if (tmr >= STARTUP_CYC - 40'h1) begin
						state <= S_IDLE;
						tmr <= 40'h0;
					end
				end
				S_IDLE: begin
					if (press_evt) begin
						state <= S_HOLD;
						sel <= 3'd0;
						tmr <= 40'h0;
					end
				end
				S_HOLD: begin
					if (release_evt) begin
						tmr <= 40'h0;
						test_fail <= 1'b0;
						aim_af <= 1'b0;
						case (sel)
							3'd1: state <= S_TEST;
							3'd2: state <= S_AIM;
							3'd3: state <= S_SETUP;
							3'd4: begin
								state <= S_LEARN;
								good_spot <= 1'b0;
							end
							default: state <= S_IDLE;
						endcase
					end else if (tmr >= STEP_CYC - 40'h1) begin
						tmr <= 40'h0;
						sel <= (sel == 3'd4) ? 3'd1 : sel + 3'd1;
					end
				end
				S_TEST: begin
					if (evt[`BLS_EVT_READ_FAIL]) begin
						test_fail <= 1'b1;
					end else if (evt[`BLS_EVT_READ_GOOD]) begin
						test_fail <= 1'b0;
					end
					if (press_evt || tmr >= TEST_TO_CYC - 40'h1) begin
						state <= S_IDLE;
						tmr <= 40'h0;
					end
				end
				S_AIM: begin
					if (ctrl[`BLS_CTRL_LENS] && tmr >= AIM_DLY_CYC - 40'h1) begin
						aim_af <= 1'b1;
					end
					if (press_evt) begin
						state <= S_AIM_CANCEL;
						tmr <= 40'h0;
					end
				end
				S_AIM_CANCEL: begin
					if (tmr >= CANCEL_CYC - 40'h1) begin
						state <= S_IDLE;
						aim_af <= 1'b0;
						tmr <= 40'h0;
					end
				end
				S_SETUP: begin
					if (evt[`BLS_EVT_SETUP_OK]) begin
						setup_store <= 1'b1;
						state <= S_BEEP;
						beep_hi <= 1'b1;
						beeps_left <= `BLS_HIGH_BEEPS;
						beep_phase <= 1'b1;
						tmr <= 40'h0;
					end else if (tmr >= SETUP_TO_CYC - 40'h1) begin
						state <= S_BEEP;
						beep_hi <= 1'b0;
						beeps_left <= `BLS_LOW_BEEPS;
						beep_phase <= 1'b1;
						tmr <= 40'h0;
					end
				end
				S_LEARN: begin
					if (press_evt) begin
						state <= S_LEARN_CANCEL;
						tmr <= 40'h0;
					end else if (evt[`BLS_EVT_LEARN_OK]) begin
						learn_store <= 1'b1;
						good_spot <= 1'b1;
						state <= S_BEEP;
						beep_hi <= 1'b1;
						beeps_left <= `BLS_HIGH_BEEPS;
						beep_phase <= 1'b1;
						tmr <= 40'h0;
					end else if (tmr >= LEARN_TO_CYC - 40'h1) begin
						state <= S_BEEP;
						beep_hi <= 1'b0;
						beeps_left <= `BLS_LOW_BEEPS;
						beep_phase <= 1'b1;
						tmr <= 40'h0;
					end
				end
				S_LEARN_CANCEL: begin
					if (tmr >= CANCEL_CYC - 40'h1) begin
						state <= S_IDLE;
						tmr <= 40'h0;
					end
				end
				S_BEEP: begin
					if (beep_phase) begin
						if (tmr >= (beep_hi ? BEEP_SHORT_CYC : BEEP_LONG_CYC) - 40'h1) begin
							beep_phase <= 1'b0;
							beeps_left <= beeps_left - 2'd1;
							tmr <= 40'h0;
						end
					end else if (tmr >= BEEP_GAP_CYC - 40'h1) begin
						tmr <= 40'h0;
						if (beeps_left == 2'd0) begin
							state <= S_IDLE;
						end else begin
							beep_phase <= 1'b1;
						end
					end
				end
				default: begin
					state <= S_IDLE;
					tmr <= 40'h0;
				end
			endcase
		end
	end

	// Indicator pattern: status, serial, trigger, good, ready
	always @* begin
		case (state)
			S_STARTUP: next_led = {5{blink}};
			S_IDLE: next_led = ctrl[`BLS_CTRL_ERR] ? {blink, 3'h0, blink} : 5'h00;
			S_HOLD: next_led = sel_led(sel);
			S_TEST: begin
				if (test_fail) begin
					next_led = {blink, 4'h0};
				end else begin
					next_led = {rate >= 7'd100, rate >= 7'd80, rate >= 7'd60, rate >= 7'd40,
						rate >= 7'd20};
				end
			end
			S_AIM, S_AIM_CANCEL: next_led = sel_led(3'd2) & {5{blink}};
			S_SETUP: next_led = sel_led(3'd3) & {5{blink}};
			S_LEARN, S_LEARN_CANCEL: next_led = sel_led(3'd4) & {5{blink}};
			default: next_led = 5'h00;
		endcase
	end

	// Registered outputs
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			led_status <= 1'b0;
			serial_activity_indicator <= 1'b0;
			led_trigger <= 1'b0;
			led_good <= 1'b0;
			led_ready <= 1'b0;
			laser_on <= 1'b0;
			autofocus_run <= 1'b0;
			setup_run <= 1'b0;
			learn_run <= 1'b0;
			beep_high <= 1'b0;
			beep_low <= 1'b0;
			diag_msg_req <= 1'b0;
			err_seen <= 1'b0;
		end else begin
			led_status <= next_led[4];
			serial_activity_indicator <= next_led[3];
			led_trigger <= next_led[2];
			led_good <= next_led[1];
			led_ready <= next_led[0];
			laser_on <= (state == S_AIM) | (state == S_AIM_CANCEL);
			autofocus_run <= aim_af;
			setup_run <= (state == S_SETUP);
			learn_run <= (state == S_LEARN);
			beep_high <= (state == S_BEEP) & beep_phase & beep_hi;
			beep_low <= (state == S_BEEP) & beep_phase & ~beep_hi;
			err_seen <= ctrl[`BLS_CTRL_ERR];
			diag_msg_req <= ctrl[`BLS_CTRL_DIAG] & ctrl[`BLS_CTRL_ERR] & ~err_seen;
		end
	end
endmodule // bls_top

/* File: bls_regs.vh */
// What this block does
// - First button press lights the status indicator at once.
// - Holding the button steps through test, aim, setup and learn.
// - Release enters the function whose indicator is lit.
// - Test mode shows the good-read rate as a five-indicator bar graph.
// - Test mode read failure blinks only the status indicator.
// - One press during test mode leaves test mode.
// - Test mode ends by itself after three minutes.
// - Aim switches lasers on and blinks the aim indicator while active.
// - After a short aim delay, autofocus starts on software-focus lens variants.
// - A press during aim cancels autofocus and lasers after a short delay.
// - Setup runs calibration and blinks the setup indicator until done.
// - Setup success stores parameters, stops blinking, sounds three short high beeps.
// - Setup failing for five seconds quits unsaved with one long low beep.
// - Learn detects one code; each new learn replaces the last.
// - The learn indicator blinks until learning completes.
// - Learn success stores parameters, lights good-read spot, three high beeps.
// - Learn failing for three minutes quits unsaved with one long low beep.
// - A press during learning stops it at once and returns to idle after a short delay.
// - Errors blink status and ready together while idle, other three indicators off.
// - An option sends diagnostic messages describing the error condition.
// - At startup all five indicators blink for one second.
`ifndef BLS_REGS_VH
`define BLS_REGS_VH

`define BLS_CLK_HZ 40'd50000000

// Register offsets
`define BLS_REG_CTRL 8'h00
`define BLS_REG_EVT 8'h04
`define BLS_REG_RATE 8'h08
`define BLS_REG_STAT 8'h0C

// Control fields
`define BLS_CTRL_LENS 0
`define BLS_CTRL_DIAG 1
`define BLS_CTRL_ERR 2
`define BLS_CTRL_RESET 3'h0

// Event fields, write one to pulse
`define BLS_EVT_READ_GOOD 0
`define BLS_EVT_READ_FAIL 1
`define BLS_EVT_SETUP_OK 2
`define BLS_EVT_LEARN_OK 3

`define BLS_RATE_RESET 7'h00

// Times in their own units
`define BLS_STARTUP_MS 40'd1000
`define BLS_TEST_TIMEOUT_S 40'd180
`define BLS_SETUP_TIMEOUT_S 40'd5
`define BLS_LEARN_TIMEOUT_S 40'd180
`define BLS_STEP_MS 40'd1000
`define BLS_CANCEL_MS 40'd200
`define BLS_BLINK_MS 40'd250
`define BLS_AIM_DELAY_MS 40'd500
`define BLS_BEEP_SHORT_MS 40'd100
`define BLS_BEEP_GAP_MS 40'd100
`define BLS_BEEP_LONG_MS 40'd1000
`define BLS_DEBOUNCE_MS 40'd10

`define BLS_HIGH_BEEPS 2'd3
`define BLS_LOW_BEEPS 2'd1

`endif

/* File: bls_debounce.v */
`timescale 1ns/1ns
`include "bls_regs.vh"

module bls_debounce #(
	parameter [39:0] DEB_CYC = 40'd500000
) (
	input wire sys_clk,
	input wire rst,
	input wire button_in,
	output reg pressed,
	output reg press_evt,
	output reg release_evt
);
	reg sync1;
	reg sync2;
	reg sync3;
	reg [39:0] cnt;

	// Three-stage synchroniser, stable only when stages two and three agree
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			cnt <= 40'h0;
			pressed <= 1'b0;
			press_evt <= 1'b0;
			release_evt <= 1'b0;
		end else begin
			sync1 <= button_in;
			sync2 <= sync1;
			sync3 <= sync2;
			press_evt <= 1'b0;
			release_evt <= 1'b0;
			if (sync2 != sync3 || sync3 == pressed) begin
				cnt <= 40'h0;
			end else if (cnt >= DEB_CYC - 40'h1) begin
				cnt <= 40'h0;
				pressed <= sync3;
				press_evt <= sync3;
				release_evt <= ~sync3;
			end else begin
				cnt <= cnt + 40'h1;
			end
		end
	end
endmodule // bls_debounce

/* File: bls_operator.sv */
`timescale 1ns/1ns
module bls_operator (
	input wire logic sys_clk,
	output logic button_in
);
	initial button_in = 1'b0;
	// Press, keep held for n cycles, let go
	task automatic hold(input int n);
		@(posedge sys_clk);
		button_in <= 1'b1;
		repeat (n) @(posedge sys_clk);
		button_in <= 1'b0;
	endtask
endmodule // bls_operator

/* File: bls_monitor.sv */
`timescale 1ns/1ns
module bls_monitor (
	input wire sys_clk,
	input wire rst,
	input wire led_status,
	input wire serial_activity_indicator,
	input wire led_trigger,
	input wire led_good,
	input wire led_ready,
	input wire laser_on,
	input wire autofocus_run,
	input wire setup_run,
	input wire setup_store,
	input wire learn_run,
	input wire learn_store,
	input wire good_spot,
	input wire beep_high,
	input wire beep_low
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_all_lit;
		led_status && serial_activity_indicator && led_trigger && led_good && led_ready;
	endsequence
	sequence s_short;
		beep_high [*4] ##1 !beep_high;
	endsequence
	property p_boot; $fell(rst) |-> ##[0:2] s_all_lit; endproperty
	property p_af; autofocus_run |-> laser_on; endproperty
	property p_cancel; $fell(laser_on) |-> !autofocus_run; endproperty
	property p_excl; !(setup_run && learn_run); endproperty
	property p_sstore; setup_store |-> ##1 !setup_store ##[0:2] beep_high; endproperty
	property p_lstore; learn_store |-> ##[0:3] good_spot; endproperty
	property p_tone; !(beep_high && beep_low); endproperty
	property p_send; $fell(setup_run) |-> ##[0:2] (beep_high || beep_low); endproperty
	property p_relearn; $rose(learn_run) |-> ##[0:1] !good_spot; endproperty
	property p_short; $rose(beep_high) |-> s_short; endproperty
	property p_long; $rose(beep_low) |-> beep_low [*8] ##1 beep_low [*2] ##1 !beep_low; endproperty
	a_boot: assert property (p_boot) else $error("No startup blink");
	a_af: assert property (p_af) else $error("Autofocus without lasers");
	a_cancel: assert property (p_cancel) else $error("Autofocus kept after lasers off");
	a_excl: assert property (p_excl) else $error("Two functions at once");
	a_sstore: assert property (p_sstore) else $error("Setup store without beeps");
	a_lstore: assert property (p_lstore) else $error("Learn store without spot");
	a_tone: assert property (p_tone) else $error("Both tones at once");
	a_send: assert property (p_send) else $error("Setup ended silently");
	a_relearn: assert property (p_relearn) else $error("Spot kept on new learn");
	a_short: assert property (p_short) else $error("Short beep length wrong");
	a_long: assert property (p_long) else $error("Long beep length wrong");
endmodule // bls_monitor
bind bls_top bls_monitor bls_monitor_inst (.sys_clk, .rst, .led_status, .serial_activity_indicator, .led_trigger,
	.led_good, .led_ready, .laser_on, .autofocus_run, .setup_run, .setup_store, .learn_run, .learn_store,
	.good_spot, .beep_high, .beep_low);

/* File: bls_tb_top.sv */
`timescale 1ns/1ns
module bls_tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic er;
	wire button_in;
	wire [31:0] prdata;
	wire pready, pslverr, led_status, serial_activity_indicator, led_trigger, led_good, led_ready;
	wire laser_on, autofocus_run, setup_run, learn_run, good_spot, beep_high, beep_low;
	wire setup_store, learn_store, diag_msg_req;
	wire [4:0] leds = {led_status, serial_activity_indicator, led_trigger, led_good, led_ready};
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	int nh;
	int nl;
	int ns;
	int np;
	// Shortened timing so every function fits in a short run
	localparam [39:0] STARTUP_CYC = 40'h14;
	localparam [39:0] TEST_TO_CYC = 40'hC8;
	localparam [39:0] SETUP_TO_CYC = 40'h64;
	localparam [39:0] LEARN_TO_CYC = 40'hC8;
	localparam [39:0] STEP_CYC = 40'h10;
	localparam [39:0] CANCEL_CYC = 40'h4;
	localparam [39:0] BLINK_CYC = 40'h4;
	localparam [39:0] AIM_DLY_CYC = 40'h8;
	localparam [39:0] BEEP_SHORT_CYC = 40'h4;
	localparam [39:0] BEEP_GAP_CYC = 40'h4;
	localparam [39:0] BEEP_LONG_CYC = 40'hA;
	localparam [39:0] DEB_CYC = 40'h4;
	always #10 sys_clk = ~sys_clk;
	bls_operator bls_operator_inst (.sys_clk(sys_clk), .button_in(button_in));
	bls_top #(.STARTUP_CYC(STARTUP_CYC), .TEST_TO_CYC(TEST_TO_CYC), .SETUP_TO_CYC(SETUP_TO_CYC),
		.LEARN_TO_CYC(LEARN_TO_CYC), .STEP_CYC(STEP_CYC), .CANCEL_CYC(CANCEL_CYC), .BLINK_CYC(BLINK_CYC),
		.AIM_DLY_CYC(AIM_DLY_CYC), .BEEP_SHORT_CYC(BEEP_SHORT_CYC), .BEEP_GAP_CYC(BEEP_GAP_CYC),
		.BEEP_LONG_CYC(BEEP_LONG_CYC), .DEB_CYC(DEB_CYC)) bls_top_inst (.sys_clk, .rst,
		.button_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .led_status,
		.serial_activity_indicator, .led_trigger, .led_good, .led_ready, .laser_on, .autofocus_run, .setup_run,
		.setup_store, .learn_run, .learn_store, .good_spot, .beep_high, .beep_low, .diag_msg_req);
	task automatic end_of_test;
		$display("Checks %0d, errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			end_of_test;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic chk1(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic state(input logic [31:0] s);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd & 32'h0003FF00, s << 8);
	endtask
	// Hold long enough for k steps of the cycle, then let it settle
	task automatic enter(input int k);
		bls_operator_inst.hold(16 * k + 8);
		repeat (12) @(posedge sys_clk);
	endtask
	// Count beep cycles, store pulses and cycles showing LED pattern p
	task automatic beeps(input int n, input logic [4:0] p);
		nh = 0;
		nl = 0;
		ns = 0;
		np = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			nh += int'(beep_high === 1'b1);
			nl += int'(beep_low === 1'b1);
			ns += int'(leds === p);
			np += int'(setup_store === 1'b1 || learn_store === 1'b1);
		end
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		beeps(8, 5'h1F);
		chk(ns, 32'h4);
		repeat (22) @(posedge sys_clk);
		state(32'h2);
		apb(1'b0, 8'h10, 32'h0);
		chk1(er, 1'b1);
		apb(1'b1, 8'h00, 32'h7);
		@(negedge sys_clk);
		@(negedge sys_clk);
		chk1(diag_msg_req, 1'b1);
		@(negedge sys_clk);
		chk1(diag_msg_req, 1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h7);
		repeat (3) @(posedge sys_clk);
		chk({28'h0, leds[3:1], leds[4] ^ leds[0]}, 32'h0);
		beeps(8, 5'h11);
		chk(ns, 32'h4);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h08, 32'h3C);
		enter(1);
		state(32'h8);
		chk({27'h0, leds}, 32'h7);
		apb(1'b1, 8'h04, 32'h2);
		repeat (3) @(negedge sys_clk);
		chk({28'h0, leds[3:0]}, 32'h0);
		beeps(8, 5'h10);
		chk(ns, 32'h4);
		bls_operator_inst.hold(8);
		repeat (12) @(posedge sys_clk);
		state(32'h2);
		enter(1);
		repeat (220) @(posedge sys_clk);
		state(32'h2);
		enter(2);
		chk1(laser_on, 1'b1);
		chk1(autofocus_run, 1'b0);
		beeps(8, 5'h04);
		chk(ns, 32'h4);
		chk1(autofocus_run, 1'b1);
		bls_operator_inst.hold(8);
		repeat (2) @(posedge sys_clk);
		chk1(laser_on, 1'b1);
		repeat (14) @(posedge sys_clk);
		chk1(laser_on, 1'b0);
		chk1(autofocus_run, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		enter(2);
		repeat (16) @(posedge sys_clk);
		chk1(autofocus_run, 1'b0);
		bls_operator_inst.hold(8);
		repeat (16) @(posedge sys_clk);
		enter(3);
		chk1(setup_run, 1'b1);
		beeps(8, 5'h02);
		chk(ns, 32'h4);
		apb(1'b1, 8'h04, 32'h4);
		beeps(60, 5'h00);
		chk(nh, 32'hC);
		chk(np, 32'h1);
		chk(nl, 32'h0);
		state(32'h2);
		enter(3);
		repeat (80) @(posedge sys_clk);
		beeps(40, 5'h00);
		chk(nl, 32'hA);
		chk(np, 32'h0);
		enter(4);
		beeps(8, 5'h01);
		chk(ns, 32'h4);
		apb(1'b1, 8'h04, 32'h8);
		beeps(60, 5'h00);
		chk1(good_spot, 1'b1);
		chk(nh, 32'hC);
		chk(np, 32'h1);
		enter(4);
		chk1(good_spot, 1'b0);
		bls_operator_inst.hold(8);
		repeat (16) @(posedge sys_clk);
		chk1(learn_run, 1'b0);
		state(32'h2);
		enter(4);
		repeat (180) @(posedge sys_clk);
		beeps(40, 5'h00);
		chk(nl, 32'hA);
		chk(np, 32'h0);
		state(32'h2);
		end_of_test;
	end
endmodule // bls_tb_top
